//--- design/ecs_pkg.sv
package ecs_pkg;

   // ==========================================================
   // Widths and fixed codes
   // ==========================================================
   localparam int unsigned STATUS_W = 4;
   localparam int unsigned CURR_W = 12;
   localparam int unsigned TIME_W = 16;
   localparam logic [3:0] CODE_AUTO = 4'h0;
   localparam logic [3:0] CODE_MAX_POINT = 4'ha;
   localparam logic [3:0] CODE_PURGE_H2S = 4'hc;
   localparam logic [3:0] CODE_AUTOCAL = 4'hd;
   localparam logic [3:0] CODE_ALARM_RST = 4'he;

   // Current inputs in units of 1/16 mA
   localparam logic [11:0] CURR_HIGH_MIN = 12'h0b0;
   localparam logic [11:0] CURR_ZERO_LVL = 12'h040;
   localparam logic [11:0] CURR_HALF_MA = 12'h008;
   localparam int unsigned CURR_FRAC_BITS = 4;

   // ==========================================================
   // Timing: phase times are given in seconds
   // ==========================================================
   localparam int unsigned CLOCK_HZ = 25_000_000;
   localparam int unsigned TICK_MS = 1;
   localparam int unsigned TICK_CYCLES = CLOCK_HZ / 1000 * TICK_MS;
   localparam int unsigned MS_PER_S = 1000;

   // ==========================================================
   // Reset values
   // ==========================================================
   localparam logic [3:0] STATUS_RST = 4'h0;
   localparam logic [15:0] TIMER_RST = 16'h0000;

   // ==========================================================
   // Types
   // ==========================================================
   typedef enum logic [2:0] {
      ECS_OFF = 3'h0,
      ECS_RELAY4 = 3'h1,
      ECS_CURR4 = 3'h2,
      ECS_CURR1 = 3'h3,
      ECS_FIELDBUS = 3'h4
   } ecs_source_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ZERO = 3'b001,
      ST_ASPIRATE = 3'b011,
      ST_MEASURE = 3'b010,
      ST_SB_PURGE = 3'b110,
      ST_STANDBY = 3'b111,
      ST_AUTO = 3'b101
   } ecs_state_t;

   typedef struct packed {
      logic [15:0] zero_s;
      logic [15:0] aspirate_s;
      logic [15:0] standby_purge_s;
   } ecs_times_t;

   typedef struct packed {
      logic pump_on;
      logic valves_open;
      logic zero_gas_valve;
      logic [3:0] point;
   } ecs_gas_t;

endpackage : ecs_pkg

//--- design/ecs_sequencer.sv
`timescale 1ns/100ps
module ecs_sequencer (
   input wire logic i_clock,
   input wire logic i_resetn,
   input wire logic i_io_module_fitted,
   input wire logic i_ext_enable,
   input wire ecs_pkg::ecs_source_t i_source,
   input wire logic i_biogas_variant,
   input wire logic [3:0] i_points_installed,
   input wire ecs_pkg::ecs_times_t i_times,
   input wire logic [3:0] i_relay_contacts,
   input wire logic [3:0] i_fieldbus_status,
   input wire logic [11:0] i_cmd_current_in_0,
   input wire logic [11:0] i_cmd_current_in_1,
   input wire logic [11:0] i_cmd_current_in_2,
   input wire logic [11:0] i_cmd_current_in_3,
   output logic o_active,
   output logic [3:0] o_status,
   output ecs_pkg::ecs_state_t o_state,
   output ecs_pkg::ecs_gas_t o_gas,
   output logic o_auto_switching,
   output logic o_measuring,
   output logic o_h2s_purge,
   output logic o_autocal_start,
   output logic o_alarm_reset
);
   import ecs_pkg::*;

   // ==========================================================
   // Status number decode
   // ==========================================================
   logic [3:0] bits4;
   logic [3:0] level1;
   logic [3:0] raw_status;
   logic [11:0] above_zero;
   logic [7:0] rounded;
   logic decode_on;

   always_comb begin
      bits4[0] = (i_cmd_current_in_0 >= CURR_HIGH_MIN);
      bits4[1] = (i_cmd_current_in_1 >= CURR_HIGH_MIN);
      bits4[2] = (i_cmd_current_in_2 >= CURR_HIGH_MIN);
      bits4[3] = (i_cmd_current_in_3 >= CURR_HIGH_MIN);
   end

   // Rounding adds half a mA before truncating the fraction
   always_comb begin
      above_zero = 12'h000;
      rounded = 8'h00;
      level1 = 4'h0;
      if (i_cmd_current_in_0 > CURR_ZERO_LVL) begin
         above_zero = 12'(i_cmd_current_in_0 - CURR_ZERO_LVL);
      end
      rounded = 8'((above_zero + CURR_HALF_MA) >> CURR_FRAC_BITS);
      if (rounded > 8'h0f) begin
         level1 = 4'hf;
      end else begin
         level1 = rounded[3:0];
      end
   end

   always_comb begin
      decode_on = i_io_module_fitted && i_ext_enable;
      raw_status = STATUS_RST;
      case (i_source)
         ECS_RELAY4: raw_status = i_relay_contacts;
         ECS_CURR4: raw_status = bits4;
         ECS_CURR1: raw_status = level1;
         ECS_FIELDBUS: raw_status = i_fieldbus_status;
         default: decode_on = 1'b0;
      endcase
   end

   // ==========================================================
   // Registered status and change detection
   // ==========================================================
   logic [3:0] status_q, status_d;
   logic active_q, active_d;
   logic changed;

   always_comb begin
      active_d = decode_on;
      status_d = decode_on ? raw_status : STATUS_RST;
   end

   always_ff @(posedge i_clock) begin
      if (!i_resetn) begin
         status_q <= STATUS_RST;
         active_q <= 1'b0;
      end else begin
         status_q <= status_d;
         active_q <= active_d;
      end
   end

   // A fresh enable counts as a change so the first command acts
   assign changed = (status_d != status_q) || (active_d && !active_q);

   // ==========================================================
   // Millisecond tick and phase timer
   // ==========================================================
   logic [14:0] div_q, div_d;
   logic tick;
   logic [15:0] sec_q, sec_d;
   logic [9:0] ms_q, ms_d;

   always_comb begin
      tick = (div_q == 15'(TICK_CYCLES - 1));
      div_d = tick ? 15'h0000 : 15'(div_q + 15'h0001);
   end

   always_ff @(posedge i_clock) begin
      if (!i_resetn) begin
         div_q <= 15'h0000;
      end else begin
         div_q <= div_d;
      end
   end

   // ==========================================================
   // Phase timer
   // ==========================================================
   logic timer_clr;
   logic sec_tick;

   // Clearing the millisecond count as well keeps a phase from ending
   // up to a second early
   always_comb begin
      sec_tick = tick && (ms_q == 10'(MS_PER_S - 1));
      ms_d = ms_q;
      sec_d = sec_q;
      if (timer_clr) begin
         ms_d = 10'h000;
         sec_d = TIMER_RST;
      end else if (sec_tick) begin
         ms_d = 10'h000;
         // Saturate so a very long phase never wraps to a short one
         sec_d = (sec_q == 16'hffff) ? sec_q : 16'(sec_q + 16'h0001);
      end else if (tick) begin
         ms_d = 10'(ms_q + 10'h001);
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_resetn) begin
         ms_q <= 10'h000;
         sec_q <= TIMER_RST;
      end else begin
         ms_q <= ms_d;
         sec_q <= sec_d;
      end
   end

   // ==========================================================
   // Sequencer
   // ==========================================================
   ecs_state_t state_q, state_d;
   logic [3:0] point_q, point_d;
   logic is_point;
   logic is_standby;
   logic phase_done;
   logic [15:0] limit;
   logic cal_d, alarm_d, purge_d;

   always_comb begin
      is_point = (status_d != CODE_AUTO) && (status_d <= CODE_MAX_POINT)
         && (status_d <= i_points_installed);
      is_standby = (status_d > i_points_installed)
         && (status_d != CODE_PURGE_H2S) && (status_d != CODE_AUTOCAL)
         && (status_d != CODE_ALARM_RST);
      if (status_d > CODE_MAX_POINT && status_d != CODE_PURGE_H2S
            && status_d != CODE_AUTOCAL && status_d != CODE_ALARM_RST) begin
         is_standby = 1'b1;
      end
      case (state_q)
         ST_ZERO: limit = i_times.zero_s;
         ST_ASPIRATE: limit = i_times.aspirate_s;
         ST_SB_PURGE: limit = i_times.standby_purge_s;
         default: limit = TIMER_RST;
      endcase
      phase_done = (sec_q >= limit);
   end

   always_comb begin
      state_d = state_q;
      point_d = point_q;
      cal_d = 1'b0;
      alarm_d = 1'b0;
      purge_d = o_h2s_purge;
      timer_clr = 1'b0;
      if (!active_d) begin
         state_d = ST_IDLE;
         purge_d = 1'b0;
      end else if (changed) begin
         // Every accepted command restarts the phase clock, pulse codes too
         timer_clr = 1'b1;
         purge_d = 1'b0;
         if (status_d == CODE_AUTO) begin
            state_d = ST_AUTO;
         end else if (is_point) begin
            point_d = status_d;
            state_d = ST_ZERO;
         end else if (is_standby) begin
            state_d = ST_SB_PURGE;
         end else if (status_d == CODE_PURGE_H2S) begin
            purge_d = i_biogas_variant;
         end else if (status_d == CODE_AUTOCAL) begin
            cal_d = 1'b1;
         end else begin
            alarm_d = 1'b1;
         end
      end else begin
         case (state_q)
            ST_ZERO: if (phase_done) begin
               state_d = ST_ASPIRATE;
               timer_clr = 1'b1;
            end
            ST_ASPIRATE: if (phase_done) begin
               state_d = ST_MEASURE;
            end
            ST_SB_PURGE: if (phase_done) begin
               state_d = ST_STANDBY;
            end
            default: state_d = state_q;
         endcase
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_resetn) begin
         state_q <= ST_IDLE;
         point_q <= 4'h0;
         o_autocal_start <= 1'b0;
         o_alarm_reset <= 1'b0;
         o_h2s_purge <= 1'b0;
      end else begin
         state_q <= state_d;
         point_q <= point_d;
         o_autocal_start <= cal_d;
         o_alarm_reset <= alarm_d;
         o_h2s_purge <= purge_d;
      end
   end

   // ==========================================================
   // Registered outputs
   // ==========================================================
   ecs_gas_t gas_d;
   logic auto_d, meas_d;

   always_comb begin
      gas_d.point = point_d;
      gas_d.zero_gas_valve = (state_d == ST_ZERO) || (state_d == ST_SB_PURGE);
      gas_d.valves_open = (state_d == ST_ASPIRATE) || (state_d == ST_MEASURE);
      // Standby purge runs the pump; settled standby stops it
      gas_d.pump_on = (state_d != ST_STANDBY) && (state_d != ST_IDLE)
         && (state_d != ST_AUTO);
      if (state_d == ST_STANDBY) begin
         gas_d.valves_open = 1'b0;
         gas_d.zero_gas_valve = 1'b0;
      end
   end

   always_comb begin
      auto_d = (state_d == ST_AUTO);
      meas_d = (state_d == ST_MEASURE);
   end

   always_ff @(posedge i_clock) begin
      if (!i_resetn) begin
         o_active <= 1'b0;
         o_status <= STATUS_RST;
         o_state <= ST_IDLE;
         o_gas <= '0;
         o_auto_switching <= 1'b0;
         o_measuring <= 1'b0;
      end else begin
         o_active <= active_d;
         o_status <= status_d;
         o_state <= state_d;
         o_gas <= gas_d;
         o_auto_switching <= auto_d;
         o_measuring <= meas_d;
      end
   end

endmodule : ecs_sequencer

//--- verification/ecs_ctrl_model.sv
`timescale 1ns/100ps
module ecs_ctrl_model
   import ecs_pkg::*;
(
   input wire logic [3:0] i_code,
   input wire logic i_single,
   output logic [11:0] o_cur0,
   output logic [11:0] o_cur1,
   output logic [11:0] o_cur2,
   output logic [11:0] o_cur3
);
   // ==========================================================
   // Loop currents
   // ==========================================================
   always_comb begin
      if (i_single) begin
         // 7/16 mA above each step, so rounding must go down
         o_cur0 = CURR_ZERO_LVL + {i_code, 4'h7};
         o_cur1 = 12'h000;
         o_cur2 = 12'h000;
         o_cur3 = 12'h000;
      end else begin
         // Worst-case levels right at either side of the threshold
         o_cur0 = i_code[0] ? CURR_HIGH_MIN : 12'h0af;
         o_cur1 = i_code[1] ? CURR_HIGH_MIN : 12'h0af;
         o_cur2 = i_code[2] ? CURR_HIGH_MIN : 12'h0af;
         o_cur3 = i_code[3] ? CURR_HIGH_MIN : 12'h0af;
      end
   end
endmodule : ecs_ctrl_model

//--- verification/ecs_sequencer_asserts.sv
`timescale 1ns/100ps
module ecs_asserts
   import ecs_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_resetn,
   input wire logic i_io_module_fitted,
   input wire logic i_ext_enable,
   input wire ecs_pkg::ecs_source_t i_source,
   input wire logic i_biogas_variant,
   input wire logic [3:0] i_points_installed,
   input wire logic [11:0] i_cmd_current_in_0,
   input wire logic [11:0] i_cmd_current_in_1,
   input wire logic [11:0] i_cmd_current_in_2,
   input wire logic [11:0] i_cmd_current_in_3,
   input wire logic [3:0] o_status,
   input wire ecs_pkg::ecs_state_t o_state,
   input wire ecs_pkg::ecs_gas_t o_gas,
   input wire logic o_measuring,
   input wire logic o_h2s_purge,
   input wire logic o_autocal_start,
   input wire logic o_alarm_reset
);
   // ==========================================================
   // Thresholded inputs, most significant first
   // ==========================================================
   logic [3:0] bits4;
   assign bits4 = {i_cmd_current_in_3 >= CURR_HIGH_MIN,
      i_cmd_current_in_2 >= CURR_HIGH_MIN,
      i_cmd_current_in_1 >= CURR_HIGH_MIN,
      i_cmd_current_in_0 >= CURR_HIGH_MIN};
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_resetn);
   not_fitted_a:
   assert property (!i_io_module_fitted |=> o_state == ST_IDLE &&
      o_status == 4'h0) else $error("active without module");
   source_off_a:
   assert property (i_source == ECS_OFF |=> o_status == 4'h0 &&
      o_state == ST_IDLE) else $error("active with source off");
   four_bits_a:
   assert property (i_io_module_fitted && i_ext_enable &&
      i_source == ECS_CURR4 |=> o_status == $past(bits4))
      else $error("four-input status wrong");
   standby_off_a:
   assert property (o_state == ST_STANDBY |-> !o_gas.pump_on &&
      !o_gas.valves_open) else $error("standby left gas on");
   sb_purge_a:
   assert property (o_state == ST_SB_PURGE |-> o_gas.zero_gas_valve &&
      !o_gas.valves_open) else $error("standby purge wrong");
   autocal_pulse_a:
   assert property (o_autocal_start |-> o_status == CODE_AUTOCAL ##1
      !o_autocal_start) else $error("autocal pulse wrong");
   alarm_pulse_a:
   assert property (o_alarm_reset |-> o_status == CODE_ALARM_RST ##1
      !o_alarm_reset) else $error("alarm reset pulse wrong");
   measure_hold_a:
   assert property (o_measuring ##1 $stable(o_status) &&
      o_status != 4'h0 |-> o_measuring) else $error("measure dropped");
   aspirate_first_a:
   assert property ($rose(o_measuring) |-> $past(o_state) == ST_ASPIRATE)
      else $error("measure without aspiration");
   point_zero_a:
   assert property ($changed(o_status) && o_status != 4'h0 &&
      o_status <= i_points_installed |-> o_state == ST_ZERO)
      else $error("point change without zero");
   h2s_gate_a:
   assert property ($rose(o_h2s_purge) |-> $past(i_biogas_variant) &&
      o_status == CODE_PURGE_H2S) else $error("sulphide purge not allowed");
endmodule : ecs_asserts

bind ecs_sequencer ecs_asserts i_chk (.i_clock, .i_resetn,
   .i_io_module_fitted, .i_ext_enable, .i_source, .i_biogas_variant,
   .i_points_installed, .o_h2s_purge,
   .i_cmd_current_in_0, .i_cmd_current_in_1, .i_cmd_current_in_2,
   .i_cmd_current_in_3, .o_status, .o_state, .o_gas, .o_measuring,
   .o_autocal_start, .o_alarm_reset);

//--- verification/ecs_sequencer_tb.sv
`timescale 1ns/100ps
module ecs_sequencer_tb;
   import ecs_pkg::*;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic on = 1'b0;
   logic fit = 1'b1;
   logic single = 1'b0;
   logic bio = 1'b1;
   ecs_source_t src = ECS_OFF;
   logic [3:0] code = 4'h0;
   logic [11:0] c0, c1, c2, c3;
   logic act, meas, auto, h2s, cal, arst;
   logic [3:0] st;
   ecs_state_t state;
   ecs_gas_t gas;
   int miscompares = 0;
   int checked = 0;
   always #20 clk = ~clk;
   ecs_sequencer i_dut (.i_clock(clk), .i_resetn(rstn),
      .i_io_module_fitted(fit), .i_ext_enable(on), .i_source(src),
      .i_biogas_variant(bio), .i_points_installed(4'h4), .i_times('0),
      .i_relay_contacts(code), .i_fieldbus_status(code),
      .i_cmd_current_in_0(c0), .i_cmd_current_in_1(c1),
      .i_cmd_current_in_2(c2), .i_cmd_current_in_3(c3),
      .o_active(act), .o_status(st), .o_state(state), .o_gas(gas),
      .o_auto_switching(auto), .o_measuring(meas), .o_h2s_purge(h2s),
      .o_autocal_start(cal), .o_alarm_reset(arst));
   ecs_ctrl_model i_ctrl (.i_code(code), .i_single(single),
      .o_cur0(c0), .o_cur1(c1), .o_cur2(c2), .o_cur3(c3));
   // ==========================================================
   // Tasks
   // ==========================================================
   task summarize;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : summarize
   task check(string n, logic [7:0] s, logic [7:0] e);
      checked++;
      if (s !== e) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask : check
   // Status is registered, so look one edge after the change
   task apply(logic f, ecs_source_t s, logic [3:0] c);
      @(posedge clk);
      on <= f;
      src <= s;
      single <= (s == ECS_CURR1);
      code <= c;
      @(posedge clk);
      #1;
   endtask : apply
   task wait_meas;
      int n;
      for (n = 0; n < 50 && meas !== 1'b1; n++) begin
         @(posedge clk);
         #1;
      end
      if (meas !== 1'b1) begin
         miscompares++;
         summarize();
      end
   endtask : wait_meas
   // ==========================================================
   // Sequence
   // ==========================================================
   initial begin
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      apply(1'b0, ECS_CURR4, 4'h3);
      check("status", st, 8'h0);
      check("active", act, 8'h0);
      @(posedge clk);
      fit <= 1'b0;
      apply(1'b1, ECS_CURR4, 4'h3);
      check("status", st, 8'h0);
      check("active", act, 8'h0);
      @(posedge clk);
      fit <= 1'b1;
      apply(1'b1, ECS_OFF, 4'h3);
      check("state", state, ST_IDLE);
      check("active", act, 8'h0);
      apply(1'b1, ECS_RELAY4, 4'h3);
      check("status", st, 8'h3);
      check("active", act, 8'h1);
      apply(1'b1, ECS_FIELDBUS, 4'h9);
      check("status", st, 8'h9);
      for (int m = 0; m < 2; m++) begin
         for (int c = 0; c < 16; c++) begin
            apply(1'b1, m ? ECS_CURR1 : ECS_CURR4, c[3:0]);
            check("status", st, c[7:0]);
            check("auto", auto, c == 0);
            check("h2s", h2s, c == 12);
            check("autocal", cal, c == 13);
            check("alarm", arst, c == 14);
         end
      end
      apply(1'b1, ECS_CURR4, 4'h2);
      check("state", state, ST_ZERO);
      wait_meas();
      check("point", gas.point, 8'h2);
      check("valves", gas.valves_open, 8'h1);
      repeat (5) @(posedge clk);
      #1;
      check("meas", meas, 8'h1);
      apply(1'b1, ECS_CURR4, 4'h3);
      check("state", state, ST_ZERO);
      apply(1'b1, ECS_CURR4, 4'hf);
      check("state", state, ST_SB_PURGE);
      check("zero valve", gas.zero_gas_valve, 8'h1);
      @(posedge clk);
      #1;
      check("state", state, ST_STANDBY);
      check("pump", gas.pump_on, 8'h0);
      apply(1'b1, ECS_CURR4, 4'h1);
      check("state", state, ST_ZERO);
      wait_meas();
      // A short pulse of fifteen forces a fresh zero at the same point
      apply(1'b1, ECS_CURR4, 4'hf);
      apply(1'b1, ECS_CURR4, 4'h1);
      check("state", state, ST_ZERO);
      apply(1'b1, ECS_CURR4, 4'h5);
      check("state", state, ST_SB_PURGE);
      @(posedge clk);
      bio <= 1'b0;
      apply(1'b1, ECS_CURR4, 4'hc);
      check("h2s", h2s, 8'h0);
      @(posedge clk);
      rstn <= 1'b0;
      @(posedge clk);
      #1;
      check("state", state, ST_IDLE);
      check("status", st, 8'h0);
      @(posedge clk);
      rstn <= 1'b1;
      apply(1'b1, ECS_CURR4, 4'h1);
      check("state", state, ST_ZERO);
      wait_meas();
      check("point", gas.point, 8'h1);
      summarize();
   end
endmodule : ecs_sequencer_tb
